// File: rtl/lsim_indicator_mux.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module lsim_indicator_mux #(
  parameter int SYNC_WINDOW = lsim_pkg::LSIM_SYNC_WINDOW,
  parameter int LOSS_ERRORS = lsim_pkg::LSIM_LOSS_ERRORS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Receive path sources
  input wire logic rxSlicedPos,
  input wire logic rxSlicedNeg,
  input wire logic rxRecoveredClk,
  input wire logic rxPatternBit,
  input wire logic rxPatternError,
  input wire logic lineAlarmStatus,
  input wire logic lineSignalLoss,
  input wire logic lineExcessZeroes,
  input wire logic lineBipolarViolation,
  // Transmit path sources
  input wire logic txPatternBit,
  input wire logic txPatternError,
  input wire logic systemAlarmStatus,
  input wire logic overcurrentStatus,
  input wire logic txLineLossStatus,
  input wire logic systemSignalLoss,
  input wire logic systemExcessZeroes,
  input wire logic systemBipolarViolation,
  // Multiplexed pins
  output logic rxNegativeRailData,
  output logic rxRecoveredClockOut,
  output logic txNegativeRailData,
  input wire logic txNegRailIn,
  output logic txNegRailDrive,
  output logic rxPatternSync,
  output logic txPatternSync
);
  import lsim_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Build-time limits
  // Counters are sized from the window, so other windows still fit
  localparam int CW = $clog2(SYNC_WINDOW + 1);
  localparam logic [CW-1:0] WIN_LAST = CW'(SYNC_WINDOW);
  localparam logic [CW-1:0] ERR_LIMIT = CW'(LOSS_ERRORS);

  generate
    if (SYNC_WINDOW < 2 || LOSS_ERRORS < 1 || LOSS_ERRORS >= SYNC_WINDOW) begin : gBadParams
      $error("sync window or error limit out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] rxCfg_r;
  logic [7:0] txCfg_r;
  logic waitDone_r;
  logic [2:0] rxSel;
  logic [2:0] txSel;
  logic rxNrz;
  logic [1:0] txFmt;
  logic txNrz;
  logic busReq;

  assign busReq = avsRead | avsWrite;
  assign rxSel = rxCfg_r[LSIM_SEL_LSB +: 3];
  assign txSel = txCfg_r[LSIM_SEL_LSB +: 3];
  assign rxNrz = rxCfg_r[LSIM_RXFMT_BIT];
  assign txFmt = txCfg_r[LSIM_TXFMT_LSB +: 2];
  assign txNrz = (txFmt == LSIM_TX_NRZ);

  // One wait cycle, answer on second edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitDone_r <= 1'b0;
    end else begin
      waitDone_r <= busReq & ~waitDone_r;
    end
  end

  always_comb begin
    avsWaitRequest = busReq & ~waitDone_r;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxCfg_r <= LSIM_CFG_RESET;
      txCfg_r <= LSIM_CFG_RESET;
    end else if (avsWrite && waitDone_r) begin
      if (avsAddress == LSIM_ADDR_RXCFG) begin
        rxCfg_r <= avsWriteData[7:0];
      end
      if (avsAddress == LSIM_ADDR_TXCFG) begin
        txCfg_r <= avsWriteData[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead && !waitDone_r) begin
      unique case (avsAddress)
        LSIM_ADDR_RXCFG: avsReadData <= {24'h00_0000, rxCfg_r};
        LSIM_ADDR_TXCFG: avsReadData <= {24'h00_0000, txCfg_r};
        LSIM_ADDR_STAT: avsReadData <= {30'h0000_0000, txPatternSync, rxPatternSync};
        default: avsReadData <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pattern sync trackers, one per path
  logic [1:0] patBit;
  logic [1:0] patErr;
  logic [1:0] syncR;
  assign patBit = {txPatternBit, rxPatternBit};
  assign patErr = {txPatternError, rxPatternError};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gSync
      logic inSync_r;
      logic [CW-1:0] goodCnt_r;
      logic [SYNC_WINDOW-1:0] errHist_r;
      logic [CW-1:0] errCnt_r;
      logic [CW-1:0] winSum;
      logic lossHit;

      // Errors in the window that ends with this bit
      assign winSum = errCnt_r - CW'(errHist_r[SYNC_WINDOW-1]) + CW'(patErr[g]);
      assign lossHit = inSync_r & (winSum > ERR_LIMIT);

      // Agreement run counted only while hunting
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          inSync_r <= 1'b0;
          goodCnt_r <= '0;
        end else if (!inSync_r) begin
          if (!patBit[g]) begin
            goodCnt_r <= '0;
          end else if (goodCnt_r == WIN_LAST) begin
            inSync_r <= 1'b1;
            goodCnt_r <= '0;
          end else begin
            goodCnt_r <= goodCnt_r + CW'(1);
          end
        end else if (lossHit) begin
          inSync_r <= 1'b0;
        end
      end

      // Sliding history, so a burst across any boundary still counts
      // Costs one flop per window bit; a fixed window would miss bursts
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          errHist_r <= '0;
          errCnt_r <= '0;
        end else if (!inSync_r || lossHit) begin
          errHist_r <= '0;
          errCnt_r <= '0;
        end else begin
          errHist_r <= {errHist_r[SYNC_WINDOW-2:0], patErr[g]};
          errCnt_r <= winSum;
        end
      end

      assign syncR[g] = inSync_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Source selection
  logic rxInd;
  logic txInd;

  always_comb begin
    unique case (rxSel)
      LSIM_SEL_PAT: rxInd = syncR[0] & ~rxPatternError;
      LSIM_SEL_AIS: rxInd = lineAlarmStatus;
      LSIM_SEL_X2: rxInd = rxSlicedPos ^ rxSlicedNeg;
      LSIM_SEL_X3: rxInd = rxRecoveredClk;
      LSIM_SEL_EXZ: rxInd = lineExcessZeroes;
      LSIM_SEL_BPV: rxInd = lineBipolarViolation;
      LSIM_SEL_BOTH: rxInd = lineExcessZeroes | lineBipolarViolation;
      LSIM_SEL_LOS: rxInd = lineSignalLoss;
    endcase
  end

  always_comb begin
    unique case (txSel)
      LSIM_SEL_PAT: txInd = syncR[1] & ~txPatternError;
      LSIM_SEL_AIS: txInd = systemAlarmStatus;
      LSIM_SEL_X2: txInd = overcurrentStatus;
      LSIM_SEL_X3: txInd = txLineLossStatus;
      LSIM_SEL_EXZ: txInd = systemExcessZeroes;
      LSIM_SEL_BPV: txInd = systemBipolarViolation & ~txNrz;
      LSIM_SEL_BOTH: txInd = systemExcessZeroes | (systemBipolarViolation & ~txNrz);
      LSIM_SEL_LOS: txInd = systemSignalLoss & ~txNrz;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Pin muxing; every output registered on the line clock
  // Receive pins: the pin not carrying the indicator keeps its own role
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxNegativeRailData <= 1'b0;
      rxRecoveredClockOut <= 1'b0;
    end else begin
      rxNegativeRailData <= rxNrz ? rxInd : rxSlicedNeg;
      rxRecoveredClockOut <= rxNrz ? rxRecoveredClk : rxInd;
    end
  end

  // Transmit pin: released in dual-rail, where it carries data inward
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txNegativeRailData <= 1'b0;
      txNegRailDrive <= 1'b0;
    end else begin
      txNegativeRailData <= txInd;
      txNegRailDrive <= (txFmt == LSIM_TX_NRZ) | (txFmt == LSIM_TX_RZ);
    end
  end

  // Sync state copies for the status word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxPatternSync <= 1'b0;
      txPatternSync <= 1'b0;
    end else begin
      rxPatternSync <= syncR[0];
      txPatternSync <= syncR[1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sel_exz_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_EXZ && rxNrz && $stable(rxCfg_r)) |=>
    rxNegativeRailData == $past(lineExcessZeroes))
    else $error("rx exz indicator wrong");
  sel_los_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_LOS && !rxNrz && $stable(rxCfg_r)) |=>
    rxRecoveredClockOut == $past(lineSignalLoss))
    else $error("rx los indicator wrong");
  rx_xor_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_X2 && rxNrz) |=>
    rxNegativeRailData == ($past(rxSlicedPos) ^ $past(rxSlicedNeg)))
    else $error("rx xor indicator wrong");
  tx_nrz_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txNrz && txSel == LSIM_SEL_LOS) |=> !txNegativeRailData)
    else $error("tx reserved code not muted");
  tx_ais_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_AIS) |=> txNegativeRailData == $past(systemAlarmStatus))
    else $error("tx ais indicator wrong");
  tx_oc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_X2) |=> txNegativeRailData == $past(overcurrentStatus))
    else $error("tx overcurrent indicator wrong");
  tx_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txFmt == LSIM_TX_DUAL) |=> !txNegRailDrive)
    else $error("tx pin driven in dual rail");
  sync_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(syncR[0]) |-> $past(rxPatternBit, 1) && $past(rxPatternBit, 2))
    else $error("sync without agreement");
  rx_pat_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_PAT && rxNrz && !syncR[0]) |=> !rxNegativeRailData)
    else $error("pattern indicator high out of sync");
  cov_sync_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(syncR[0]));
  cov_loss_c: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(syncR[1]));
  cov_tx_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    txNrz && txSel == LSIM_SEL_BOTH && systemExcessZeroes);
  cov_err_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    rxSel == LSIM_SEL_PAT && syncR[0] && rxPatternError);
  cov_dual_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    txFmt == LSIM_TX_DUAL && txSel == LSIM_SEL_LOS);

  // Receive codes
  rx_ais_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_AIS && rxNrz) |=> rxNegativeRailData == $past(lineAlarmStatus))
    else $error("rx ais indicator wrong");
  rx_clk_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_X3 && !rxNrz) |=> rxRecoveredClockOut == $past(rxRecoveredClk))
    else $error("rx clock indicator wrong");
  rx_exz_dual_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_EXZ && !rxNrz) |=> rxRecoveredClockOut == $past(lineExcessZeroes))
    else $error("rx exz indicator wrong on clock pin");
  rx_bpv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_BPV && rxNrz) |=> rxNegativeRailData == $past(lineBipolarViolation))
    else $error("rx bpv indicator wrong");
  rx_both_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_BOTH && rxNrz) |=>
    rxNegativeRailData == ($past(lineExcessZeroes) | $past(lineBipolarViolation)))
    else $error("rx combined indicator wrong");
  rx_rail_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rxNrz |=> rxNegativeRailData == $past(rxSlicedNeg))
    else $error("rx negative rail not passed through");
  rx_clkpin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rxNrz |=> rxRecoveredClockOut == $past(rxRecoveredClk))
    else $error("rx clock pin not passed through");
  rx_pat_hi_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_PAT && rxNrz && syncR[0] && !rxPatternError) |=> rxNegativeRailData)
    else $error("pattern indicator low in sync");
  rx_pat_err_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxSel == LSIM_SEL_PAT && rxNrz && rxPatternError) |=> !rxNegativeRailData)
    else $error("pattern error not shown");

  // Transmit codes
  tx_pat_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_PAT && !syncR[1]) |=> !txNegativeRailData)
    else $error("tx pattern indicator high out of sync");
  tx_tx_line_signal_loss_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_X3) |=> txNegativeRailData == $past(txLineLossStatus))
    else $error("tx line loss indicator wrong");
  tx_exz_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_EXZ) |=> txNegativeRailData == $past(systemExcessZeroes))
    else $error("tx exz indicator wrong");
  tx_bpv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_BPV && !txNrz) |=> txNegativeRailData == $past(systemBipolarViolation))
    else $error("tx bpv indicator wrong");
  tx_both_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_BOTH && !txNrz) |=>
    txNegativeRailData == ($past(systemExcessZeroes) | $past(systemBipolarViolation)))
    else $error("tx combined indicator wrong");
  tx_system_signal_loss_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txSel == LSIM_SEL_LOS && !txNrz) |=> txNegativeRailData == $past(systemSignalLoss))
    else $error("tx system loss indicator wrong");
  tx_mute_bpv_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txNrz && txSel == LSIM_SEL_BPV) |=> !txNegativeRailData)
    else $error("tx bpv not muted in nrz");
  tx_nrz_both_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txNrz && txSel == LSIM_SEL_BOTH) |=> txNegativeRailData == $past(systemExcessZeroes))
    else $error("tx combined not reduced in nrz");
  tx_drive_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (txFmt != LSIM_TX_DUAL) |=> txNegRailDrive)
    else $error("tx pin not driven");

  // Sync tracking
  sync_loss_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(syncR[1]) |-> $past(txPatternError))
    else $error("sync lost without error");
  sync_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (syncR[0] && !rxPatternError) |=> syncR[0])
    else $error("sync lost on clean bit");
  stat_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    syncR[0] |=> rxPatternSync)
    else $error("rx sync status not copied");
endmodule

// File: rtl/lsim_pkg.sv
// How it works
// - Receive single-rail NRZ: indicator drives the negative-rail receive data pin.
// - Receive dual-rail sliced: indicator drives the recovered-clock pin.
// - Receive indicator source picked by 3-bit field, bits 7 to 5, rx config.
// - Rx code 000: high while pattern synced, low one cycle per error.
// - Rx code 001: follows line AIS status bit.
// - Rx code 010: XOR of positive and negative sliced data.
// - Rx code 011: recovered receive clock, same as dedicated clock output.
// - Rx code 100: one-cycle pulse per line excessive-zeroes event.
// - Rx code 101: one-cycle pulse per line bipolar or code violation.
// - Rx code 110: one-cycle pulse on either line event.
// - Rx code 111: follows line loss-of-signal status bit.
// - Transmit NRZ or dual-rail RZ: indicator drives negative-rail transmit pin.
// - Transmit indicator source picked by 3-bit field, bits 7 to 5, tx config.
// - Tx code 000: high while tx pattern synced, low one cycle per error.
// - Tx code 001: follows system AIS status bit.
// - Tx code 010: follows transmit over-current status bit.
// - Tx code 011: follows transmit line loss-of-signal status bit.
// - Tx code 100: one-cycle pulse per system excessive-zeroes event.
// - Tx code 101: one-cycle pulse per system bipolar violation.
// - Tx code 110: one-cycle pulse on either system event.
// - Tx code 111: follows system loss-of-signal status bit.
// - Tx single-rail NRZ disables codes 101, 111 and reduces 110 to excessive zeroes only; software treats them reserved.
// - Sync after over 64-bit agreement; lost on over six errors per window.
package lsim_pkg;
  localparam logic [1:0] LSIM_ADDR_RXCFG = 2'h0;
  localparam logic [1:0] LSIM_ADDR_TXCFG = 2'h1;
  localparam logic [1:0] LSIM_ADDR_STAT = 2'h2;
  localparam int LSIM_SEL_LSB = 5;
  localparam int LSIM_RXFMT_BIT = 0;
  localparam int LSIM_TXFMT_LSB = 0;
  localparam logic [7:0] LSIM_CFG_RESET = 8'h00;
  localparam logic [1:0] LSIM_TX_NRZ = 2'h0;
  localparam logic [1:0] LSIM_TX_RZ = 2'h1;
  localparam logic [1:0] LSIM_TX_DUAL = 2'h2;
  localparam int LSIM_SYNC_WINDOW = 64;
  localparam int LSIM_LOSS_ERRORS = 6;
  localparam logic [2:0] LSIM_SEL_PAT = 3'h0;
  localparam logic [2:0] LSIM_SEL_AIS = 3'h1;
  localparam logic [2:0] LSIM_SEL_X2 = 3'h2;
  localparam logic [2:0] LSIM_SEL_X3 = 3'h3;
  localparam logic [2:0] LSIM_SEL_EXZ = 3'h4;
  localparam logic [2:0] LSIM_SEL_BPV = 3'h5;
  localparam logic [2:0] LSIM_SEL_BOTH = 3'h6;
  localparam logic [2:0] LSIM_SEL_LOS = 3'h7;
endpackage

// File: verification/lsim_framer_model.sv
`timescale 1ns/1ps
module lsim_framer_model (
  // Line clock
  input wire logic ref_clk,
  // Drive enable of the device's negative-rail pin
  input wire logic txNegRailDrive,
  output logic farNegRail
);
  logic toggle = 1'b0;
  // Released pin shows changing data, never a held value
  always @(posedge ref_clk) begin
    toggle <= ~toggle;
  end
  assign farNegRail = txNegRailDrive ? ~toggle : toggle;
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lsim_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] avsAddress = 2'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rd;
  logic avsWaitRequest, rxNeg, rxClk, txNeg, txDrv, farNeg, negWire, rxSync, txSync;
  logic [16:0] src = 17'h0;
  int mismatches = 0;
  int checked = 0;
  int lo;
  assign negWire = txDrv ? txNeg : farNeg;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  lsim_indicator_mux dut (.ref_clk(ref_clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .rxSlicedPos(src[0]), .rxSlicedNeg(src[1]), .rxRecoveredClk(src[2]),
    .rxPatternBit(src[3]), .rxPatternError(src[4]), .lineAlarmStatus(src[5]),
    .lineSignalLoss(src[6]), .lineExcessZeroes(src[7]), .lineBipolarViolation(src[8]),
    .txPatternBit(src[9]), .txPatternError(src[10]), .systemAlarmStatus(src[11]),
    .overcurrentStatus(src[12]), .txLineLossStatus(src[13]), .systemSignalLoss(src[14]),
    .systemExcessZeroes(src[15]), .systemBipolarViolation(src[16]),
    .rxNegativeRailData(rxNeg), .rxRecoveredClockOut(rxClk), .txNegativeRailData(txNeg),
    .txNegRailIn(negWire), .txNegRailDrive(txDrv), .rxPatternSync(rxSync),
    .txPatternSync(txSync));
  lsim_framer_model far (.ref_clk(ref_clk), .txNegRailDrive(txDrv), .farNegRail(farNeg));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= ~w;
    // Request stands until waitrequest is seen low at a rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  function automatic logic rxf(input logic [2:0] s, input logic [16:0] v);
    logic [7:0] t;
    t = {v[6], v[7] | v[8], v[8], v[7], v[2], v[0] ^ v[1], v[5], 1'b0};
    return t[s];
  endfunction
  function automatic logic txf(input logic [2:0] s, input logic nz, input logic [16:0] v);
    logic [7:0] t;
    // Single-rail NRZ has no violation or system loss reporting
    t = {v[14] & ~nz, v[15] | (v[16] & ~nz), v[16] & ~nz, v[15], v[13], v[12], v[11], 1'b0};
    return t[s];
  endfunction
  task automatic rnd(input logic [1:0] tf, input logic rf);
    for (int s = 1; s < 8; s++) begin
      bus(1'b1, LSIM_ADDR_RXCFG, {24'h0, 3'(s), 4'h0, rf});
      bus(1'b1, LSIM_ADDR_TXCFG, {24'h0, 3'(s), 3'h0, tf});
      bus(1'b0, LSIM_ADDR_TXCFG, 32'h0);
      chk(rd, {24'h0, 3'(s), 3'h0, tf});
      repeat (6) begin
        @(posedge ref_clk);
        src <= 17'($urandom);
        @(posedge ref_clk);
        #1;
        chk(rf ? rxNeg : rxClk, rxf(3'(s), src));
        chk(txDrv, tf != LSIM_TX_DUAL);
        if (txDrv === 1'b1) chk(txNeg, txf(3'(s), tf == LSIM_TX_NRZ, src));
      end
    end
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      src <= 17'h00410;
      @(posedge ref_clk);
      src <= 17'h00208;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25ns * 20000);
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(55379));
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1'b0, LSIM_ADDR_RXCFG, 32'h0);
    chk(rd, {24'h0, LSIM_CFG_RESET});
    bus(1'b1, 2'h3, 32'hFF);
    bus(1'b0, 2'h3, 32'h0);
    chk(rd, 32'h0);
    $display("test 1 done");
    rnd(LSIM_TX_NRZ, 1'b0);
    rnd(LSIM_TX_RZ, 1'b1);
    rnd(LSIM_TX_DUAL, 1'b1);
    $display("test 2 done");
    bus(1'b1, LSIM_ADDR_RXCFG, 32'h1);
    bus(1'b1, LSIM_ADDR_TXCFG, 32'h0);
    src <= 17'h00208;
    repeat (LSIM_SYNC_WINDOW + 4) @(posedge ref_clk);
    bus(1'b0, LSIM_ADDR_STAT, 32'h0);
    chk({rd[1:0], rxNeg, txNeg, rxSync, txSync}, 6'h3F);
    lo = 0;
    fork
      errs(1);
      repeat (6) @(negedge ref_clk) lo += {rxNeg, txNeg} === 2'b00;
    join
    chk(lo, 1);
    repeat (LSIM_SYNC_WINDOW + 6) @(posedge ref_clk);
    errs(LSIM_LOSS_ERRORS);
    bus(1'b0, LSIM_ADDR_STAT, 32'h0);
    chk(rd, 32'h3);
    errs(1);
    #1;
    chk({rxNeg, txNeg, rxSync, txSync}, 4'h0);
    $display("test 3 done");
    print_verdict();
  end
endmodule
